// ==== src/fwd_watchdog.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fwd_consts.svh"
module fwd_watchdog #(
  parameter int unsigned TICK_DIV = `FWD_TICK_DIV,
  parameter int unsigned RESET_DELAY = `FWD_RESET_DELAY_US / `FWD_TICK_US,
  parameter int unsigned IGNORE_TICKS = `FWD_IGNORE_US / `FWD_TICK_US,
  parameter int unsigned SERVICE_TICKS = `FWD_SERVICE_US / `FWD_TICK_US,
  parameter int unsigned FAULT_TICKS = `FWD_FAULT_US / `FWD_TICK_US,
  parameter int unsigned FILTER_TICKS = `FWD_FILTER_US / `FWD_TICK_US
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Supply monitor.
  input wire logic undervoltage,
  // Service pin, logic level and disable level window.
  input wire logic service_in,
  input wire logic disable_level,
  // Shared open-drain reset and fault output.
  output logic reset_fault_out_n_o,
  output logic reset_fault_out_n_oe,
  // Status.
  output fwd_pkg::fwd_status_t status
);
  import fwd_pkg::*;

  localparam int unsigned CW = 16;
  localparam int unsigned DW = 8;

  // Refuse parameter values that the counters cannot serve.
  if (TICK_DIV < 2 || TICK_DIV > 255) begin : g_div_chk
    $error("fwd_watchdog TICK_DIV out of range");
  end
  if (SERVICE_TICKS >= (1 << CW) || RESET_DELAY >= (1 << CW) ||
      IGNORE_TICKS >= (1 << CW) || FAULT_TICKS >= (1 << CW) ||
      SERVICE_TICKS < 1 || IGNORE_TICKS < 1 || FAULT_TICKS < 1 ||
      RESET_DELAY < 1) begin : g_cnt_chk
    $error("fwd_watchdog period does not fit counter");
  end
  if (FILTER_TICKS * `FWD_TICK_US < `FWD_FILTER_MIN_US ||
      FILTER_TICKS * `FWD_TICK_US > `FWD_FILTER_MAX_US) begin : g_filt_chk
    $error("fwd_watchdog filter outside allowed window");
  end

  function automatic logic [CW-1:0] last_of(input int unsigned n);
    last_of = CW'(n - 1);
  endfunction

  // Three-stage synchronisers for the pin inputs.
  logic [2:0] svc_sync_ff;
  logic [2:0] dis_sync_ff;
  logic [2:0] uv_sync_ff;
  logic svc_ff;
  logic dis_ff;
  logic uv_ff;
  logic nxt_svc;
  logic nxt_dis;
  logic nxt_uv;

  always_comb begin
    nxt_svc = (svc_sync_ff[2] == svc_sync_ff[1]) ? svc_sync_ff[2] : svc_ff;
    nxt_dis = (dis_sync_ff[2] == dis_sync_ff[1]) ? dis_sync_ff[2] : dis_ff;
    nxt_uv = (uv_sync_ff[2] == uv_sync_ff[1]) ? uv_sync_ff[2] : uv_ff;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      svc_sync_ff <= 3'h0;
      dis_sync_ff <= 3'h0;
      uv_sync_ff <= 3'h7;
      svc_ff <= 1'b0;
      dis_ff <= 1'b0;
      uv_ff <= 1'b1;
    end else begin
      svc_sync_ff <= {svc_sync_ff[1:0], service_in};
      dis_sync_ff <= {dis_sync_ff[1:0], disable_level};
      uv_sync_ff <= {uv_sync_ff[1:0], undervoltage};
      svc_ff <= nxt_svc;
      dis_ff <= nxt_dis;
      uv_ff <= nxt_uv;
    end
  end

  // Falling edge of the qualified service level counts as service.
  logic svc_fall;
  assign svc_fall = svc_ff && !nxt_svc;

  // Internal timebase: one-cycle tick every TICK_DIV clocks.
  logic [DW-1:0] div_ff;
  logic [DW-1:0] nxt_div;
  logic tick;

  always_comb begin
    tick = (div_ff == DW'(TICK_DIV - 1));
    nxt_div = tick ? '0 : div_ff + DW'(1);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end

  // Filtered disable level; high means the watchdog is suspended.
  logic wd_off;
  fwd_filter #(
    .WIDTH(CW),
    .HOLD(FILTER_TICKS)
  ) u_filter (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tick(tick),
    .level_in(dis_ff),
    .level_out(wd_off)
  );

  // Supervision sequence.
  fwd_state_t state_ff;
  fwd_state_t nxt_state;
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic low_ff;
  logic nxt_low;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    // Undervoltage restarts the power-on delay from any state.
    if (uv_ff) begin
      nxt_state = FWD_POR;
      nxt_cnt = '0;
    end else begin
      case (state_ff)
        FWD_POR: begin
          if (tick) begin
            if (cnt_ff == last_of(RESET_DELAY)) begin
              nxt_state = FWD_IGNORE;
              nxt_cnt = '0;
            end else begin
              nxt_cnt = cnt_ff + CW'(1);
            end
          end
        end
        FWD_IGNORE: begin
          if (wd_off) begin
            nxt_state = FWD_OFF;
            nxt_cnt = '0;
          end else if (tick) begin
            if (cnt_ff == last_of(IGNORE_TICKS)) begin
              nxt_state = FWD_SERVICE;
              nxt_cnt = '0;
            end else begin
              nxt_cnt = cnt_ff + CW'(1);
            end
          end
        end
        FWD_SERVICE: begin
          if (wd_off) begin
            nxt_state = FWD_OFF;
            nxt_cnt = '0;
          end else if (svc_fall) begin
            nxt_cnt = '0;
          end else if (tick) begin
            if (cnt_ff == last_of(SERVICE_TICKS)) begin
              nxt_state = FWD_FAULT;
              nxt_cnt = '0;
            end else begin
              nxt_cnt = cnt_ff + CW'(1);
            end
          end
        end
        FWD_FAULT: begin
          if (tick) begin
            if (cnt_ff == last_of(FAULT_TICKS)) begin
              nxt_state = wd_off ? FWD_OFF : FWD_IGNORE;
              nxt_cnt = '0;
            end else begin
              nxt_cnt = cnt_ff + CW'(1);
            end
          end
        end
        FWD_OFF: begin
          if (!wd_off) begin
            nxt_state = FWD_IGNORE;
            nxt_cnt = '0;
          end
        end
        default: begin
          nxt_state = FWD_POR;
          nxt_cnt = '0;
        end
      endcase
    end
    nxt_low = (nxt_state == FWD_POR) || (nxt_state == FWD_FAULT);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff <= FWD_POR;
      cnt_ff <= '0;
      low_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      low_ff <= nxt_low;
    end
  end

  // The pin is pulled low while the enable is high; its data stays low.
  assign reset_fault_out_n_o = 1'b0;
  assign reset_fault_out_n_oe = low_ff;
  assign status = '{
    fault_low: low_ff,
    wd_enabled: (state_ff != FWD_OFF),
    in_service: (state_ff == FWD_SERVICE)
  };
endmodule // fwd_watchdog
`default_nettype wire

// ==== inc/fwd_consts.svh ====
// Function
// - Pull the output low when no falling edge arrives within the trigger period.
// - All intervals are counted from the internal timebase, no external clock.
// - Ignore period of 16 ms starts when the output is released high.
// - After the ignore period a 48 ms trigger period opens.
// - A falling edge during the trigger period restarts it.
// - A timeout holds the output low for 8 ms, then releases it.
// - Disable level acts after being held for 300 us, within the 100 us to 500 us window.
// - Disable excursions shorter than 100 us are ignored.
// - Undervoltage reset and timeout share one active-low output.
// - After power-on the output stays low 8.5 ms before supervision starts.
// - After a fault pulse a new ignore period runs, or the watchdog goes off if the filtered disable level is high.
// - While disabled the output stays high; on removal ignore then trigger. A fault pulse already under way still runs to its end.
`ifndef FWD_CONSTS_SVH
`define FWD_CONSTS_SVH
`define FWD_CLK_HZ 50000000
`define FWD_TICK_US 1
`define FWD_TICK_DIV (`FWD_CLK_HZ / 1000000 * `FWD_TICK_US)
`define FWD_IGNORE_US 16000
`define FWD_SERVICE_US 48000
`define FWD_FAULT_US 8000
`define FWD_RESET_DELAY_US 8500
`define FWD_FILTER_MIN_US 100
`define FWD_FILTER_MAX_US 500
`define FWD_FILTER_US 300
`endif

// ==== inc/fwd_pkg.sv ====
package fwd_pkg;
  typedef enum logic [2:0] {
    FWD_POR,
    FWD_IGNORE,
    FWD_SERVICE,
    FWD_FAULT,
    FWD_OFF
  } fwd_state_t;
  typedef struct packed {
    logic fault_low;
    logic wd_enabled;
    logic in_service;
  } fwd_status_t;
endpackage

// ==== src/fwd_filter.sv ====
`timescale 1ns/1ps
`default_nettype none
module fwd_filter #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned HOLD = 300
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Timebase tick and raw level.
  input wire logic tick,
  input wire logic level_in,
  // Filtered level.
  output logic level_out
);
  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  logic out_ff;
  logic nxt_out;

  // Refuse a hold count that the counter cannot reach.
  if (HOLD < 1 || HOLD >= (64'd1 << WIDTH)) begin : g_hold_chk
    $error("fwd_filter HOLD does not fit WIDTH");
  end

  // The output follows the input only after it has differed for HOLD ticks.
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    if (level_in == out_ff) begin
      nxt_cnt = '0;
    end else if (tick) begin
      if (cnt_ff == WIDTH'(HOLD - 1)) begin
        nxt_out = level_in;
        nxt_cnt = '0;
      end else begin
        nxt_cnt = cnt_ff + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
      out_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      out_ff <= nxt_out;
    end
  end

  assign level_out = out_ff;
endmodule // fwd_filter
`default_nettype wire

// ==== test/fwd_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module fwd_chk (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Pins and status.
  input wire logic undervoltage,
  input wire logic service_in,
  input wire logic disable_level,
  input wire logic reset_fault_out_n_o,
  input wire logic reset_fault_out_n_oe,
  input wire fwd_pkg::fwd_status_t status
);
  import fwd_pkg::*;
  logic oe;
  logic svc_ff, nxt_svc;
  logic [10:0] hi_ff, quiet_ff, dhi_ff, dlo_ff;
  logic [10:0] nxt_hi, nxt_quiet, nxt_dhi, nxt_dlo;
  assign oe = reset_fault_out_n_oe;
  always_comb begin
    nxt_svc = service_in;
    nxt_hi = oe ? hi_ff + 11'h1 : 11'h0;
    nxt_quiet = quiet_ff + 11'h1;
    if (oe || !status.wd_enabled || (svc_ff && !service_in && status.in_service)) begin
      nxt_quiet = 11'h0;
    end
    nxt_dhi = disable_level ? dhi_ff + 11'(dhi_ff != 11'h7FF) : 11'h0;
    nxt_dlo = !disable_level ? dlo_ff + 11'(dlo_ff != 11'h7FF) : 11'h0;
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {svc_ff, hi_ff, quiet_ff, dhi_ff, dlo_ff} <= '0;
    end else begin
      {svc_ff, hi_ff, quiet_ff} <= {nxt_svc, nxt_hi, nxt_quiet};
      {dhi_ff, dlo_ff} <= {nxt_dhi, nxt_dlo};
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_timeout;
    $rose(oe) ##0 $past(status.in_service);
  endsequence
  a_uv_low: assert property (undervoltage |-> ##[1:6] oe)
    else $error("undervoltage did not pull output low");
  a_pulse_len: assert property ($fell(oe) |-> hi_ff inside {[38:52]})
    else $error("low pulse width off");
  a_ignore_len: assert property ($rose(status.in_service) |-> quiet_ff inside {[36:44]})
    else $error("ignore period length off");
  a_no_early: assert property (s_timeout |-> quiet_ff >= 11'd78)
    else $error("timeout came early");
  a_due: assert property (quiet_ff < 11'd130)
    else $error("timeout missing");
  a_off_high: assert property (!status.wd_enabled && $past(!status.wd_enabled) |-> !oe)
    else $error("output low while disabled");
  a_filt_min: assert property ($fell(status.wd_enabled) |-> dhi_ff >= 11'd200)
    else $error("disable taken too soon");
  a_en_min: assert property ($rose(status.wd_enabled) |-> dlo_ff >= 11'd200)
    else $error("enable taken too soon");
  a_filt_max: assert property (dhi_ff > 11'd1050 |-> !status.wd_enabled)
    else $error("disable not taken");
endmodule // fwd_chk
bind fwd_watchdog fwd_chk chk_u (.clk_sys, .rstn, .undervoltage, .service_in,
  .disable_level, .reset_fault_out_n_o, .reset_fault_out_n_oe, .status);
`default_nettype wire

// ==== test/fwd_mcu.sv ====
`timescale 1ns/1ps
`default_nettype none
module fwd_mcu (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Service request and pin.
  input wire logic kick,
  output logic service_in
);
  logic [2:0] cnt_ff, nxt_cnt;
  always_comb begin
    nxt_cnt = cnt_ff;
    if (kick && cnt_ff == 3'h0) begin
      nxt_cnt = 3'h5;
    end else if (cnt_ff != 3'h0) begin
      nxt_cnt = cnt_ff - 3'h1;
    end
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 3'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  assign service_in = (cnt_ff != 3'h0);
endmodule // fwd_mcu
`default_nettype wire

// ==== test/test_fixed_timeout_watchdog.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_fixed_timeout_watchdog;
  import fwd_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic undervoltage = 1'b0;
  logic disable_level = 1'b0;
  logic kick = 1'b0;
  logic service_in, oe, od;
  fwd_status_t st;
  int failures = 0;
  int compares = 0;
  int n;
  always #10 clk_sys = ~clk_sys;
  fwd_mcu mcu_u (.clk_sys, .rstn, .kick, .service_in);
  fwd_watchdog #(.TICK_DIV(2), .RESET_DELAY(20), .IGNORE_TICKS(20),
    .SERVICE_TICKS(40), .FAULT_TICKS(20)) dut_u (.clk_sys, .rstn,
    .undervoltage, .service_in, .disable_level, .reset_fault_out_n_o(od),
    .reset_fault_out_n_oe(oe), .status(st));
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic meas(input logic v, output int c);
    c = 0;
    while (oe !== v) begin
      @(negedge clk_sys);
      c++;
      if (c > 3000) begin
        failures++;
        $display("wrong value at %0t: wait ran out", $time);
        complete_run();
      end
    end
  endtask
  task automatic serve;
    @(posedge clk_sys);
    kick <= 1'b1;
    @(posedge clk_sys);
    kick <= 1'b0;
  endtask
  task automatic t_por;
    meas(1'b0, n);
    chk(n <= 60, "power-on hold");
    meas(1'b1, n);
    chk(n >= 116 && n <= 126, "first timeout");
    chk(st.fault_low === 1'b1 && st.in_service === 1'b0, "fault status");
    chk(od === 1'b0, "open-drain data not low");
    meas(1'b0, n);
    chk(n >= 38 && n <= 42, "fault pulse");
    chk(st.fault_low === 1'b0, "fault status stuck");
    meas(1'b1, n);
    chk(n >= 116 && n <= 126, "timeout after pulse");
    meas(1'b0, n);
    $display("test power-on done");
  endtask
  task automatic t_ign;
    repeat (20) @(posedge clk_sys);
    serve();
    meas(1'b1, n);
    chk(n >= 92 && n <= 104, "edge in ignore");
    meas(1'b0, n);
    $display("test ignore edge done");
  endtask
  task automatic t_serve;
    repeat (30) @(posedge clk_sys);
    n = 0;
    repeat (4) begin
      repeat (60) begin
        @(negedge clk_sys);
        if (oe !== 1'b0) n++;
      end
      serve();
    end
    chk(n == 0, "served but faulted");
    meas(1'b1, n);
    chk(n >= 84 && n <= 96, "restart time");
    meas(1'b0, n);
    $display("test service done");
  endtask
  task automatic t_dis;
    @(posedge clk_sys);
    disable_level <= 1'b1;
    n = 0;
    repeat (150) begin
      @(negedge clk_sys);
      if (st.wd_enabled !== 1'b1) n++;
    end
    @(posedge clk_sys);
    disable_level <= 1'b0;
    repeat (20) begin
      @(negedge clk_sys);
      if (st.wd_enabled !== 1'b1) n++;
    end
    chk(n == 0, "short disable taken");
    @(posedge clk_sys);
    disable_level <= 1'b1;
    repeat (1100) @(posedge clk_sys);
    n = 0;
    repeat (400) begin
      @(negedge clk_sys);
      if (oe !== 1'b0 || st.wd_enabled !== 1'b0) n++;
    end
    chk(n == 0, "disabled state");
    @(posedge clk_sys);
    disable_level <= 1'b0;
    n = 0;
    while (st.wd_enabled !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n++;
    end
    chk(n >= 200 && n <= 1010, "enable delay");
    if (n >= 2000) begin
      complete_run();
    end
    meas(1'b1, n);
    chk(n >= 116 && n <= 126, "ignore then trigger");
    meas(1'b0, n);
    $display("test disable done");
  endtask
  task automatic t_uv;
    @(posedge clk_sys);
    undervoltage <= 1'b1;
    meas(1'b1, n);
    chk(n <= 6, "undervoltage reaction");
    repeat (4) @(posedge clk_sys);
    undervoltage <= 1'b0;
    meas(1'b0, n);
    chk(n >= 40 && n <= 52, "reset delay");
    $display("test undervoltage done");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    t_por();
    t_ign();
    t_serve();
    t_dis();
    t_uv();
    complete_run();
  end
endmodule // test_fixed_timeout_watchdog
`default_nettype wire
